// *** hdl/diag_pkg.sv ***
/*
  Constants for the diagnostics, output-pin and flash-count register block:
  register offsets, field positions, reset values and command bits.
  Assumes a 16-bit SPI frame: bit 15 write flag, [14:8] address, [7:0] data.
*/
// Function
// - Two pin function fields, codes 00/01/10/11
// - Per-pin polarity bits; control resets to 0x0008
// - Flags coexist; live condition sets flag again
// - Node bits [4:0] latched until clear; bits 6:5 until clear or next result
// - Node alarm byte latches only when enabled
// - Gateway system alarm, node data, completion flags
// - Gateway bit 3 flags bad clock count
// - Bits 1/0 flag supply high/low
// - Bit 6 checksum fail, bit 2 update fail
// - Node alarm levels per axis, system error
// - Node self-test result bit 5, record bit 4
// - Self-test command starts test, reports bit 5
// - Checksum command runs test, reports bit 6
// - Seven read-only 16-bit flash write counters
// - Both status registers read zero after reset
// - Gateway page 0, nodes pages 1 to 6
// - Command bit returns to zero when done
package diag_pkg;
  // ---------------------------------------------------------------
  // Register offsets (low byte address)
  // ---------------------------------------------------------------
  localparam logic [6:0] ADDR_PAGE = 7'h00;
  localparam logic [6:0] ADDR_FLASH_CNT = 7'h04;
  localparam logic [6:0] ADDR_PIN_CTRL = 7'h2a;
  localparam logic [6:0] ADDR_GW_STAT = 7'h2c;
  localparam logic [6:0] ADDR_NODE_STAT = 7'h34;
  localparam logic [6:0] ADDR_GLOB_CMD = 7'h36;
  localparam logic [6:0] ADDR_ALARM_CONTROL = 7'h50;
  // ---------------------------------------------------------------
  // Pages and sizes
  // ---------------------------------------------------------------
  localparam logic [2:0] PAGE_GW = 3'h0;
  localparam logic [2:0] PAGE_LAST = 3'h6;
  localparam int NODES = 6;
  localparam int CNT_WORDS = 7;
  localparam logic [3:0] LAST_BIT = 4'hf;
  localparam int RW_BIT = 15;
  // ---------------------------------------------------------------
  // Output pin control fields
  // ---------------------------------------------------------------
  localparam logic [5:0] PIN_CTRL_RESET = 6'h08;
  localparam int FN2_LO = 4;
  localparam int FN1_LO = 2;
  localparam int POL2 = 1;
  localparam int POL1 = 0;
  localparam logic [1:0] FN_GPO = 2'h0;
  localparam logic [1:0] FN_ALARM = 2'h1;
  localparam logic [1:0] FN_BUSY = 2'h2;
  // ---------------------------------------------------------------
  // Status bit positions
  // ---------------------------------------------------------------
  localparam logic [15:0] STAT_RESET = 16'h0000;
  localparam int ST_SYS = 14;
  localparam int GW_NEW_LO = 8;
  localparam int GW_DONE = 7;
  localparam int ST_FLASH = 6;
  localparam int ST_SELF = 5;
  localparam int ST_REC = 4;
  localparam int GW_SPI = 3;
  localparam int ST_FUPD = 2;
  localparam int ST_VHI = 1;
  localparam int ST_VLO = 0;
  localparam int ALM2Y = 12;
  localparam int ALM2X = 11;
  localparam int ALM1Y = 9;
  localparam int ALM1X = 8;
  // ---------------------------------------------------------------
  // Global command bits and alarm control
  // ---------------------------------------------------------------
  localparam int CMD_SELF = 2;
  localparam int CMD_CLR = 4;
  localparam int CMD_FLASH = 5;
  localparam logic [15:0] CMD_CLR_MASK = 16'h0010;
  localparam int ALM_LATCH_BIT = 7;
  typedef enum logic {CMD_IDLE = 1'b0, CMD_BUSY = 1'b1} cmd_state_e;
endpackage : diag_pkg

// *** hdl/flash_cnt_if.sv ***
/*
  Carrier between the register block and its flash counter memory.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface flash_cnt_if;
  logic ce;            // Clock enable
  logic inc;           // Count one flash write
  logic [2:0] inc_idx; // Which counter, 0 gateway, 1..6 nodes
  logic [2:0] rd_idx;  // Counter to present
  logic [15:0] rd_data; // Registered read word
  modport ctrl(output ce, output inc, output inc_idx, output rd_idx,
    input rd_data);
  modport mem(input ce, input inc, input inc_idx, input rd_idx,
    output rd_data);
endinterface : flash_cnt_if

// *** hdl/flash_cnt_mem.sv ***
/*
  Seven 16-bit flash write counters with a registered read port.
  Assumes inc and rd_idx come from logic on the same clock.
*/
`timescale 1ns/1ps
module flash_cnt_mem (
  input wire logic mclk,
  input wire logic arst_n,
  flash_cnt_if.mem bus
);
  logic [15:0] word_q [diag_pkg::CNT_WORDS]; // One counter per page
  logic [15:0] rd_q; // Read register

  // ---------------------------------------------------------------
  // Counters
  // ---------------------------------------------------------------
  for (genvar i = 0; i < diag_pkg::CNT_WORDS; i++) begin : g_word
    // Wraps silently at 0xffff; endurance is far below that anyway
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        word_q[i] <= 16'h0000;
      end else if (bus.ce && bus.inc && bus.inc_idx == 3'(i)) begin
        word_q[i] <= word_q[i] + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  // Out of range index reads zero rather than an undefined word
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_q <= 16'h0000;
    end else if (bus.ce) begin
      if (bus.rd_idx <= diag_pkg::PAGE_LAST) begin
        rd_q <= word_q[bus.rd_idx];
      end else begin
        rd_q <= 16'h0000;
      end
    end
  end
  assign bus.rd_data = rd_q;
endmodule : flash_cnt_mem

// *** hdl/diag_regs.sv ***
/*
  Diagnostics register bank: output pin control, gateway and node status,
  global commands and flash write counters behind a 16-bit SPI port.
  Assumes SPI mode 3 with SCLK well below a quarter of mclk; condition
  inputs and command handshakes come from logic on mclk.
*/
`timescale 1ns/1ps
module diag_regs (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_din,
  output logic spi_dout,
  input wire logic gw_supply_high,
  input wire logic gw_supply_low,
  input wire logic gw_flash_update_fail,
  input wire logic gw_system_alarm,
  input wire logic [5:0] node_new_data,
  input wire logic [5:0] node_supply_high,
  input wire logic [5:0] node_supply_low,
  input wire logic [5:0] node_flash_update_fail,
  input wire logic [5:0] node_record_interrupted,
  input wire logic [5:0] node_system_error,
  input wire logic [23:0] node_alarm,
  input wire logic flash_write,
  input wire logic [2:0] flash_write_idx,
  input wire logic [1:0] gpo_level,
  input wire logic busy_ready,
  output logic cmd_start,
  output logic [15:0] cmd_bits,
  output logic [2:0] cmd_node,
  input wire logic cmd_done,
  input wire logic cmd_selftest_fail,
  input wire logic cmd_flash_fail,
  output logic digital_out_first,
  output logic digital_out_second
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Word match ignores the byte select bit
  function automatic logic word_hit(input logic [6:0] a,
                                    input logic [6:0] t);
    word_hit = (a[6:1] == t[6:1]);
  endfunction : word_hit

  // Pin level from function code, polarity and sources
  function automatic logic pin_level(input logic [1:0] fn,
                                     input logic pol, input logic gpo,
                                     input logic alm, input logic busy);
    logic act;
    act = 1'b0;
    case (fn)
      diag_pkg::FN_GPO: act = gpo;
      diag_pkg::FN_ALARM: act = alm;
      diag_pkg::FN_BUSY: act = busy;
      default: act = 1'b0;
    endcase
    pin_level = pol ? act : ~act;
  endfunction : pin_level

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic sclk_m_q, sclk_s_q, sclk_d_q; // SCLK stages and history
  logic cs_m_q, cs_s_q, cs_d_q; // Chip select stages and history
  logic din_m_q, din_s_q; // Data in stages

  // First stages feed only the second stages
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_m_q <= 1'b1;
      sclk_s_q <= 1'b1;
      sclk_d_q <= 1'b1;
      cs_m_q <= 1'b1;
      cs_s_q <= 1'b1;
      cs_d_q <= 1'b1;
      din_m_q <= 1'b0;
      din_s_q <= 1'b0;
    end else if (ce) begin
      sclk_m_q <= spi_sclk;
      sclk_s_q <= sclk_m_q;
      sclk_d_q <= sclk_s_q;
      cs_m_q <= spi_cs_n;
      cs_s_q <= cs_m_q;
      cs_d_q <= cs_s_q;
      din_m_q <= spi_din;
      din_s_q <= din_m_q;
    end
  end

  logic sclk_rise, sclk_fall, cs_fall, cs_rise;
  assign sclk_rise = sclk_s_q & ~sclk_d_q & ~cs_s_q;
  assign sclk_fall = ~sclk_s_q & sclk_d_q & ~cs_s_q;
  assign cs_fall = ~cs_s_q & cs_d_q;
  assign cs_rise = cs_s_q & ~cs_d_q;

  // ---------------------------------------------------------------
  // Frame receive and decode
  // ---------------------------------------------------------------
  logic [14:0] rx_q; // Bits shifted in so far
  logic [3:0] bit_cnt_q; // Edges in the current frame
  logic [15:0] frame; // Completed frame word
  logic frame_done, wr, rd;
  logic [6:0] f_addr;
  logic [7:0] f_data;
  logic [15:0] cmd_w; // Byte in its lane; data bit 1 also asks self-test

  assign frame = {rx_q, din_s_q};
  assign frame_done = sclk_rise && (bit_cnt_q == diag_pkg::LAST_BIT);
  assign wr = frame_done & frame[diag_pkg::RW_BIT];
  assign rd = frame_done & ~frame[diag_pkg::RW_BIT];
  assign f_addr = frame[14:8];
  assign f_data = frame[7:0];
  assign cmd_w = f_addr[0] ? {f_data, 8'h00} :
    {8'h00, f_data[7:3], |f_data[2:1], 1'b0, f_data[0]};

  // Count resets on deselect so a short frame cannot skew the next
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_q <= 15'h0000;
      bit_cnt_q <= 4'h0;
    end else if (ce) begin
      if (cs_s_q) begin
        bit_cnt_q <= 4'h0;
      end else if (sclk_rise) begin
        rx_q <= frame[14:0];
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Page and control registers
  // ---------------------------------------------------------------
  logic [2:0] page_q; // Selected page
  logic [5:0] pin_ctrl_q; // Output pin control
  logic [5:0] alm_latch_q; // Alarm latch enable per node
  logic node_page;
  logic [2:0] node_idx;
  assign node_page = (page_q != diag_pkg::PAGE_GW);
  assign node_idx = page_q - 3'h1;

  // Writes to any other address fall through untouched
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      page_q <= diag_pkg::PAGE_GW;
      pin_ctrl_q <= diag_pkg::PIN_CTRL_RESET;
      alm_latch_q <= 6'h00;
    end else if (ce && wr) begin
      if (f_addr == diag_pkg::ADDR_PAGE &&
          f_data[2:0] <= diag_pkg::PAGE_LAST) begin
        page_q <= f_data[2:0];
      end else if (!node_page && f_addr == diag_pkg::ADDR_PIN_CTRL) begin
        pin_ctrl_q <= f_data[5:0];
      end else if (node_page && f_addr == diag_pkg::ADDR_ALARM_CONTROL) begin
        alm_latch_q[node_idx] <= f_data[diag_pkg::ALM_LATCH_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // Global command engine
  // ---------------------------------------------------------------
  diag_pkg::cmd_state_e cmd_state_q;
  logic cmd_wr_ok, clr_evt, done_evt;
  logic [15:0] ext_w; // Command bits handled outside
  assign cmd_wr_ok = wr && node_page &&
                     word_hit(f_addr, diag_pkg::ADDR_GLOB_CMD) &&
                     cmd_state_q == diag_pkg::CMD_IDLE;
  assign clr_evt = cmd_wr_ok & cmd_w[diag_pkg::CMD_CLR];
  assign ext_w = cmd_w & ~diag_pkg::CMD_CLR_MASK;
  assign done_evt = (cmd_state_q == diag_pkg::CMD_BUSY) & cmd_done;

  // One command in flight; writes while busy are dropped, because a
  // queued command would report its result against the wrong page
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_state_q <= diag_pkg::CMD_IDLE;
      cmd_bits <= 16'h0000;
      cmd_node <= 3'h0;
      cmd_start <= 1'b0;
    end else if (ce) begin
      cmd_start <= 1'b0;
      case (cmd_state_q)
        diag_pkg::CMD_IDLE: begin
          if (cmd_wr_ok && ext_w != 16'h0000) begin
            cmd_state_q <= diag_pkg::CMD_BUSY;
            cmd_bits <= ext_w;
            cmd_node <= page_q;
            cmd_start <= 1'b1;
          end
        end
        diag_pkg::CMD_BUSY: begin
          if (cmd_done) begin
            cmd_state_q <= diag_pkg::CMD_IDLE;
            cmd_bits <= 16'h0000;
          end
        end
        default: cmd_state_q <= diag_pkg::CMD_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Node status registers
  // ---------------------------------------------------------------
  logic [15:0] node_stat_q [diag_pkg::NODES];
  logic [5:0] node_alm_any; // Any upper-byte flag per node

  for (genvar n = 0; n < diag_pkg::NODES; n++) begin : g_node
    logic clr_n, res_n;
    logic [7:0] lo_c, hi_c;
    assign clr_n = clr_evt && node_idx == 3'(n);
    assign res_n = done_evt && cmd_node == 3'(n + 1);
    assign lo_c = {3'h0, node_record_interrupted[n], 1'b0,
                   node_flash_update_fail[n], node_supply_high[n],
                   node_supply_low[n]};
    assign hi_c = {1'b0, node_system_error[n], 1'b0,
                   node_alarm[4*n+3], node_alarm[4*n+2], 1'b0,
                   node_alarm[4*n+1], node_alarm[4*n]};
    assign node_alm_any[n] = |node_stat_q[n][15:8];

    // Condition is ORed after the clear so a live fault survives it
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        node_stat_q[n] <= diag_pkg::STAT_RESET;
      end else if (ce) begin
        node_stat_q[n][4:0] <= (node_stat_q[n][4:0] & ~{5{clr_n}}) |
                               lo_c[4:0];
        if (res_n && cmd_bits[diag_pkg::CMD_SELF]) begin
          node_stat_q[n][diag_pkg::ST_SELF] <= cmd_selftest_fail;
        end else if (clr_n) begin
          node_stat_q[n][diag_pkg::ST_SELF] <= 1'b0;
        end
        if (res_n && cmd_bits[diag_pkg::CMD_FLASH]) begin
          node_stat_q[n][diag_pkg::ST_FLASH] <= cmd_flash_fail;
        end else if (clr_n) begin
          node_stat_q[n][diag_pkg::ST_FLASH] <= 1'b0;
        end
        node_stat_q[n][7] <= 1'b0;
        if (alm_latch_q[n]) begin
          node_stat_q[n][15:8] <= (node_stat_q[n][15:8] & ~{8{clr_n}}) |
                                  hi_c;
        end else begin
          node_stat_q[n][15:8] <= hi_c;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Gateway status register
  // ---------------------------------------------------------------
  logic [15:0] gw_q; // Sticky gateway flags
  logic [15:0] gw_set;
  logic gw_clr; // Read of the register clears it
  logic spi_err;
  assign spi_err = cs_rise && bit_cnt_q != 4'h0;
  assign gw_set = {1'b0, gw_system_alarm, node_new_data,
                   done_evt | clr_evt,
                   done_evt & cmd_bits[diag_pkg::CMD_FLASH] & cmd_flash_fail,
                   2'b00, spi_err, gw_flash_update_fail,
                   gw_supply_high, gw_supply_low};

  // Set wins over the read clear so no event is lost
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      gw_q <= diag_pkg::STAT_RESET;
    end else if (ce) begin
      gw_q <= (gw_q & ~{16{gw_clr}}) | gw_set;
    end
  end

  // ---------------------------------------------------------------
  // Flash counters
  // ---------------------------------------------------------------
  flash_cnt_if cnt_bus ();
  assign cnt_bus.ce = ce;
  assign cnt_bus.inc = flash_write;
  assign cnt_bus.inc_idx = flash_write_idx;
  assign cnt_bus.rd_idx = page_q;

  flash_cnt_mem u_cnt (
    .mclk(mclk),
    .arst_n(arst_n),
    .bus(cnt_bus.mem)
  );

  // ---------------------------------------------------------------
  // Read path and transmit shifter
  // ---------------------------------------------------------------
  logic rd_pend_q; // Read frame seen last cycle
  logic [6:0] rd_addr_q;
  logic [15:0] tx_q; // Word being shifted out
  logic [15:0] rd_word;
  assign gw_clr = rd_pend_q && !node_page &&
                  word_hit(rd_addr_q, diag_pkg::ADDR_GW_STAT);

  // Unmapped and write-only addresses read zero
  always_comb begin
    rd_word = 16'h0000;
    if (word_hit(rd_addr_q, diag_pkg::ADDR_PAGE)) begin
      rd_word = {13'h0000, page_q};
    end else if (word_hit(rd_addr_q, diag_pkg::ADDR_FLASH_CNT)) begin
      rd_word = cnt_bus.rd_data;
    end else if (!node_page) begin
      if (word_hit(rd_addr_q, diag_pkg::ADDR_PIN_CTRL)) begin
        rd_word = {10'h000, pin_ctrl_q};
      end else if (word_hit(rd_addr_q, diag_pkg::ADDR_GW_STAT)) begin
        rd_word = gw_q;
      end
    end else if (word_hit(rd_addr_q, diag_pkg::ADDR_NODE_STAT)) begin
      rd_word = node_stat_q[node_idx];
    end else if (word_hit(rd_addr_q, diag_pkg::ADDR_ALARM_CONTROL)) begin
      rd_word = {8'h00, alm_latch_q[node_idx], 7'h00};
    end
  end

  // Answer goes out in the frame after the read request
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_pend_q <= 1'b0;
      rd_addr_q <= 7'h00;
      tx_q <= 16'h0000;
      spi_dout <= 1'b0;
    end else if (ce) begin
      rd_pend_q <= rd;
      if (rd) begin
        rd_addr_q <= f_addr;
      end
      if (rd_pend_q) begin
        tx_q <= rd_word;
        spi_dout <= rd_word[15] & ~cs_s_q;
      end else if (frame_done) begin
        tx_q <= 16'h0000;
        spi_dout <= 1'b0;
      end else if (cs_fall) begin
        spi_dout <= tx_q[15];
      end else if (sclk_fall && bit_cnt_q != 4'h0) begin // MSB stays out
        tx_q <= {tx_q[14:0], 1'b0};
        spi_dout <= tx_q[14];
      end
    end
  end

  // ---------------------------------------------------------------
  // Digital output pins
  // ---------------------------------------------------------------
  logic alarm_any;
  assign alarm_any = gw_q[diag_pkg::ST_SYS] | (|node_alm_any);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      digital_out_first <= 1'b1;
      digital_out_second <= 1'b1;
    end else if (ce) begin
      digital_out_first <= pin_level(
        pin_ctrl_q[diag_pkg::FN1_LO +: 2], pin_ctrl_q[diag_pkg::POL1],
        gpo_level[0], alarm_any, busy_ready);
      digital_out_second <= pin_level(
        pin_ctrl_q[diag_pkg::FN2_LO +: 2], pin_ctrl_q[diag_pkg::POL2],
        gpo_level[1], alarm_any, busy_ready);
    end
  end
endmodule : diag_regs

// *** testbench/spi_host.sv ***
/* Host model: drives mode 3 SPI frames, MSB first.
   Assumes mclk at 10 MHz; each sclk phase lasts 5 mclk. */
`timescale 1ns/1ps
module spi_host (
  input wire logic mclk,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_din,
  input wire logic spi_dout
);
  // Idle: clock high, select high
  initial begin
    spi_sclk = 1'b1;
    spi_cs_n = 1'b1;
    spi_din = 1'b0;
  end
  // Send n bits of w; r gets what dout showed at each rise
  task automatic xfer(input int n, input logic [15:0] w,
                      output logic [15:0] r);
    r = 16'h0000;
    @(posedge mclk) spi_cs_n <= 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      repeat (5) @(posedge mclk);
      spi_sclk <= 1'b0;
      spi_din <= w[i];
      repeat (5) @(posedge mclk);
      spi_sclk <= 1'b1;
      r[i] = spi_dout;
    end
    repeat (5) @(posedge mclk);
    spi_cs_n <= 1'b1;
    // Released line shows the inverse, not a stale bit
    spi_din <= ~spi_din;
    repeat (10) @(posedge mclk);
  endtask : xfer
endmodule : spi_host

// *** testbench/diag_regs_chk.sv ***
/* Port checker for the diagnostics register bank.
   Assumes one clock, mclk, and reset arst_n. */
`timescale 1ns/1ps
module diag_regs_chk (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic spi_cs_n,
  input wire logic spi_dout,
  input wire logic cmd_start,
  input wire logic [15:0] cmd_bits,
  input wire logic [2:0] cmd_node,
  input wire logic cmd_done,
  input wire logic digital_out_first
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_start_pulse: assert property (cmd_start |=> !cmd_start)
    else $error("cmd_start wider than one cycle");
  a_start_node: assert property (cmd_start |->
    cmd_node != 3'h0 && cmd_node <= 3'h6)
    else $error("command page outside 1 to 6");
  a_bits_hold: assert property (cmd_bits != 16'h0000 && !cmd_done
    |=> $stable(cmd_bits)) else $error("command bits moved");
  a_bits_clear: assert property (cmd_bits != 16'h0000 && cmd_done
    && ce |=> cmd_bits == 16'h0000) else $error("bits kept after done");
  a_clear_inner: assert property (!cmd_bits[4])
    else $error("clear bit leaked out");
  a_reset_out: assert property ($rose(arst_n) |-> !cmd_start
    && cmd_bits == 16'h0000 && !spi_dout) else $error("reset outputs");
  a_reset_pin: assert property ($rose(arst_n) |-> digital_out_first)
    else $error("first pin not inactive high");
  a_idle_dout: assert property (spi_cs_n [*8] |-> !spi_dout)
    else $error("dout driven while deselected");
  a_done_cause: assert property ((cmd_bits != 16'h0000) ##1
    (cmd_bits == 16'h0000) |-> $past(cmd_done))
    else $error("bits dropped without done");
endmodule : diag_regs_chk
bind diag_regs diag_regs_chk u_chk (.mclk(mclk), .arst_n(arst_n),
  .ce(ce), .spi_cs_n(spi_cs_n), .spi_dout(spi_dout),
  .cmd_start(cmd_start), .cmd_bits(cmd_bits), .cmd_node(cmd_node),
  .cmd_done(cmd_done), .digital_out_first(digital_out_first));

// *** testbench/tb.sv ***
/* Self-checking bench for diag_regs with a host model on SPI.
   Assumes 10 MHz mclk and the register map of diag_pkg. */
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0, arst_n = 1'b0, ce = 1'b1, fw = 1'b0, busy = 1'b0;
  logic gw_hi = 1'b0, gw_lo = 1'b0, gw_ff = 1'b0, gw_alm = 1'b0;
  logic [5:0] n_new = 6'h00, n_hi = 6'h00, n_lo = 6'h00, n_ff = 6'h00;
  logic [5:0] n_rec = 6'h00, n_sys = 6'h00;
  logic [23:0] n_alm = 24'h000000;
  logic [2:0] fw_idx = 3'h1, cmd_node, st_node;
  logic [1:0] gpo = 2'h2;
  logic cmd_done = 1'b0, st_fail = 1'b0, fl_fail = 1'b0;
  logic sclk, cs_n, din, dout, cmd_start, do1, do2;
  logic [15:0] cmd_bits, st_bits, rd;
  int errors = 0, n_compared = 0, cyc = 0;
  typedef struct packed {
    logic [7:0] pg;
    logic [6:0] ad;
    logic [15:0] ex;
  } row_s;
  // Reset values by page and address; 0x60 is unmapped
  row_s rows [6] = '{'{8'h00, 7'h2a, 16'h0008}, '{8'h00, 7'h2c, 16'h0000},
    '{8'h00, 7'h04, 16'h0000}, '{8'h01, 7'h34, 16'h0000},
    '{8'h01, 7'h04, 16'h0000}, '{8'h01, 7'h60, 16'h0000}};
  initial begin
    forever #50 mclk = ~mclk;
  end
  spi_host host (.mclk(mclk), .spi_sclk(sclk), .spi_cs_n(cs_n),
    .spi_din(din), .spi_dout(dout));
  diag_regs uut (.mclk(mclk), .arst_n(arst_n), .ce(ce), .spi_sclk(sclk),
    .spi_cs_n(cs_n), .spi_din(din), .spi_dout(dout),
    .gw_supply_high(gw_hi), .gw_supply_low(gw_lo),
    .gw_flash_update_fail(gw_ff), .gw_system_alarm(gw_alm),
    .node_new_data(n_new), .node_supply_high(n_hi),
    .node_supply_low(n_lo), .node_flash_update_fail(n_ff),
    .node_record_interrupted(n_rec), .node_system_error(n_sys),
    .node_alarm(n_alm), .flash_write(fw), .flash_write_idx(fw_idx),
    .gpo_level(gpo), .busy_ready(busy), .cmd_start(cmd_start),
    .cmd_bits(cmd_bits), .cmd_node(cmd_node), .cmd_done(cmd_done),
    .cmd_selftest_fail(st_fail), .cmd_flash_fail(fl_fail),
    .digital_out_first(do1), .digital_out_second(do2));
  // Capture what the launch pulse carried; it fires inside a frame
  always @(posedge mclk) begin
    if (cmd_start) begin
      st_bits <= cmd_bits;
      st_node <= cmd_node;
    end
  end
  // Hang guard: about 11250 cycles expected
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] x;
    host.xfer(16, {1'b1, a, d}, x);
  endtask : wr
  // Read answer arrives in the following frame
  task automatic rdw(input logic [6:0] a, output logic [15:0] r);
    logic [15:0] x;
    host.xfer(16, {1'b0, a, 8'h00}, x);
    host.xfer(16, 16'h0000, r);
  endtask : rdw
  task automatic pins(input logic [15:0] exp);
    repeat (4) @(posedge mclk);
    chk({14'h0000, do2, do1}, exp);
  endtask : pins
  // Engine side: check the launch, then finish with given results
  task automatic eng(input logic [15:0] eb, input logic sf, input logic ff);
    chk(st_bits, eb);
    chk({13'h0000, st_node}, 16'h0001);
    @(posedge mclk) begin
      cmd_done <= 1'b1;
      st_fail <= sf;
      fl_fail <= ff;
    end
    @(posedge mclk) cmd_done <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : eng
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    pins(16'h0001);
    foreach (rows[i]) begin
      wr(7'h00, rows[i].pg);
      rdw(rows[i].ad, rd);
      chk(rd, rows[i].ex);
    end
    $display("reset table done");
    wr(7'h00, 8'h00);
    wr(7'h2a, 8'h03);
    pins(16'h0002);
    wr(7'h2a, 8'h3f);
    pins(16'h0000);
    busy <= 1'b1;
    wr(7'h2a, 8'h28);
    pins(16'h0000);
    $display("pin function done");
    @(posedge mclk) {gw_lo, gw_alm, n_new} <= {2'h3, 6'h04};
    @(posedge mclk) {gw_lo, n_new} <= 7'h00;
    wr(7'h2a, 8'h17);
    pins(16'h0003);
    rdw(7'h2c, rd);
    chk(rd, 16'h4401);
    gw_alm <= 1'b0;
    rdw(7'h2c, rd);
    chk(rd, 16'h4000);
    pins(16'h0000);
    rdw(7'h2c, rd);
    chk(rd, 16'h0000);
    host.xfer(8, 16'hffff, rd);
    rdw(7'h2c, rd);
    chk(rd, 16'h0008);
    $display("gateway flags done");
    wr(7'h00, 8'h01);
    @(posedge mclk) n_hi <= 6'h01;
    @(posedge mclk) n_hi <= 6'h00;
    rdw(7'h34, rd);
    chk(rd, 16'h0002);
    rdw(7'h34, rd);
    chk(rd, 16'h0002);
    wr(7'h36, 8'h10);
    rdw(7'h34, rd);
    chk(rd, 16'h0000);
    wr(7'h36, 8'h02);
    eng(16'h0004, 1'b1, 1'b0);
    rdw(7'h34, rd);
    chk(rd, 16'h0020);
    wr(7'h36, 8'h20);
    eng(16'h0020, 1'b0, 1'b1);
    rdw(7'h34, rd);
    chk(rd, 16'h0060);
    wr(7'h36, 8'h02);
    eng(16'h0004, 1'b0, 1'b0);
    rdw(7'h34, rd);
    chk(rd, 16'h0040);
    n_alm <= 24'h000001;
    rdw(7'h34, rd);
    chk(rd, 16'h0140);
    n_alm <= 24'h000000;
    wr(7'h50, 8'h80);
    @(posedge mclk) {n_sys, n_alm} <= {6'h01, 24'h000008};
    @(posedge mclk) {n_sys, n_alm} <= 30'h00000000;
    rdw(7'h34, rd);
    chk(rd, 16'h5040);
    $display("node commands done");
    repeat (2) begin
      @(posedge mclk) fw <= 1'b1;
      @(posedge mclk) fw <= 1'b0;
    end
    rdw(7'h04, rd);
    chk(rd, 16'h0002);
    wr(7'h04, 8'hff);
    rdw(7'h04, rd);
    chk(rd, 16'h0002);
    wr(7'h00, 8'h00);
    rdw(7'h04, rd);
    chk(rd, 16'h0000);
    rdw(7'h2c, rd);
    chk(rd, 16'h00c0);
    $display("counters done");
    wrap_up();
  end
endmodule : tb
